// ### tcma_access.sv
// Host port decode and switch-side lookup for data and connection memories
`timescale 1ns/100ps
`default_nettype none
module tcma_access
  import tcma_pkg::*;
#(
  parameter int STREAMS = NUM_STREAMS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hostSelect_n,
  input wire logic hostRead_n,
  input wire logic hostWrite_n,
  input wire logic [HOST_ADDR_W-1:0] hostAddr,
  input wire logic [WORD_W-1:0] hostDataIn,
  output logic [WORD_W-1:0] hostDataOut,
  output logic hostDataOe,
  output logic hostAck,
  input wire logic [1:0] memorySelect,
  input wire logic [STREAMS-1:0] streamRate,
  input wire logic captureValid,
  input wire logic [STREAM_W-1:0] captureStream,
  input wire logic [CHAN_W-1:0] captureChannel,
  input wire logic [DATA_W-1:0] captureByte,
  input wire logic sampleValid,
  input wire logic [STREAM_W-1:0] sampleStream,
  input wire logic [CHAN_W-1:0] sampleChannel,
  output logic sampleDone,
  output logic [DATA_W-1:0] sampleByte,
  input wire logic lookupValid,
  input wire logic [STREAM_W-1:0] lookupStream,
  input wire logic [CHAN_W-1:0] lookupChannel,
  output logic lookupDone,
  output logic lookupInvalid,
  output logic normalSwitch,
  output logic variableDelay,
  output logic [STREAM_W-1:0] source_stream_field,
  output logic [CHAN_W-1:0] sourceChannel,
  output logic law_conversion_enable,
  output logic [WORD_W-1:0] conversionMethod
);

  typedef struct packed {
    logic strobePrev;
    logic readPend;
    logic [1:0] readSel;
    logic readValid;
    logic writeDone;
    logic [WORD_W-1:0] dataOut;
    logic dataOe;
    logic ack;
    logic samplePend;
    logic sampleDone;
    logic [DATA_W-1:0] sampleByte;
    logic lookupPend;
    logic lookupPendValid;
    logic lookupDone;
    logic lookupInvalid;
    logic normalSwitch;
    logic variableDelay;
    logic [STREAM_W-1:0] srcStream;
    logic [CHAN_W-1:0] srcChannel;
    logic lawEnable;
    logic [WORD_W-1:0] method;
  } tcma_state_t;

  tcma_state_t state_reg;
  tcma_state_t state_next;

  tcma_mem_if #(.WIDTH(DATA_W), .AW(INDEX_W)) dataPort ();
  tcma_mem_if #(.WIDTH(WORD_W), .AW(INDEX_W)) lowPort ();
  tcma_mem_if #(.WIDTH(WORD_W), .AW(INDEX_W)) highPort ();

  tcma_mem #(.WIDTH(DATA_W), .AW(INDEX_W)) dataMem (
    .clk(clk),
    .rst_n(rst_n),
    .port(dataPort)
  );

  tcma_mem #(.WIDTH(WORD_W), .AW(INDEX_W)) lowMem (
    .clk(clk),
    .rst_n(rst_n),
    .port(lowPort)
  );

  tcma_mem #(.WIDTH(WORD_W), .AW(INDEX_W)) highMem (
    .clk(clk),
    .rst_n(rst_n),
    .port(highPort)
  );

  logic [STREAM_W-1:0] hostStream;
  logic [CHAN_W-1:0] hostChannel;
  logic [INDEX_W-1:0] hostIndex;
  logic hostMemSpace;
  logic hostChanOk;
  logic strobeActive;
  logic strobeStart;
  logic hostRdTaken;
  logic hostWrTaken;
  logic lookupChanOk;
  logic [WORD_W-1:0] lowWord;

  assign hostStream = hostAddr[STREAM_LSB +: STREAM_W];
  assign hostChannel = hostAddr[CHAN_LSB +: CHAN_W];
  assign hostIndex = tcma_index(hostStream, hostChannel);
  assign hostMemSpace = hostAddr[MEM_SPACE_BIT];
  assign hostChanOk = tcma_chan_valid(streamRate[hostStream], hostChannel);
  assign lookupChanOk = tcma_chan_valid(streamRate[lookupStream], lookupChannel);

  // One access per strobe: only the leading edge is taken
  assign strobeActive = !hostSelect_n && (!hostRead_n || !hostWrite_n);
  assign strobeStart = strobeActive && !state_reg.strobePrev;
  assign hostRdTaken = strobeStart && !hostRead_n;
  assign hostWrTaken = strobeStart && hostRead_n && !hostWrite_n;

  // Host writes reach only the connection memories; data memory is owned by capture
  assign dataPort.wrEn = captureValid;
  assign dataPort.wrAddr = tcma_index(captureStream, captureChannel);
  assign dataPort.wrData = captureByte;
  assign dataPort.rdAddrA = hostIndex;
  assign dataPort.rdAddrB = tcma_index(sampleStream, sampleChannel);

  // Invalid slow-stream channels are dropped rather than aliased
  assign lowPort.wrEn = hostWrTaken && hostMemSpace && hostChanOk
                        && (memorySelect == SEL_CML);
  assign lowPort.wrAddr = hostIndex;
  assign lowPort.wrData = hostDataIn;
  assign lowPort.rdAddrA = hostIndex;
  assign lowPort.rdAddrB = tcma_index(lookupStream, lookupChannel);

  assign highPort.wrEn = hostWrTaken && hostMemSpace && hostChanOk
                         && (memorySelect == SEL_CMH);
  assign highPort.wrAddr = hostIndex;
  assign highPort.wrData = hostDataIn;
  assign highPort.rdAddrA = hostIndex;
  assign highPort.rdAddrB = tcma_index(lookupStream, lookupChannel);

  assign lowWord = lowPort.rdDataB;

  always_comb begin
    state_next = state_reg;
    state_next.strobePrev = strobeActive;
    state_next.readPend = hostRdTaken;
    state_next.readSel = memorySelect;
    state_next.readValid = hostMemSpace && hostChanOk;
    state_next.writeDone = hostWrTaken;
    state_next.ack = state_reg.readPend || state_reg.writeDone;
    // Drive the bus one cycle behind a held read strobe
    state_next.dataOe = !hostSelect_n && !hostRead_n;
    if (state_reg.readPend) begin
      if (!state_reg.readValid) begin
        state_next.dataOut = UNMAPPED_READ;
      end else begin
        case (state_reg.readSel)
          SEL_DATA: state_next.dataOut = {{(WORD_W-DATA_W){1'b0}}, dataPort.rdDataA};
          SEL_CML: state_next.dataOut = lowPort.rdDataA;
          SEL_CMH: state_next.dataOut = highPort.rdDataA;
          default: state_next.dataOut = UNMAPPED_READ;
        endcase
      end
    end

    state_next.samplePend = sampleValid;
    state_next.sampleDone = state_reg.samplePend;
    if (state_reg.samplePend) begin
      state_next.sampleByte = dataPort.rdDataB;
    end

    state_next.lookupPend = lookupValid;
    state_next.lookupPendValid = lookupChanOk;
    state_next.lookupDone = state_reg.lookupPend;
    if (state_reg.lookupPend) begin
      state_next.lookupInvalid = !state_reg.lookupPendValid;
      state_next.normalSwitch = !lowWord[CML_MODE_BIT];
      state_next.variableDelay = lowWord[CML_DELAY_BIT];
      state_next.srcStream = lowWord[CML_STREAM_LSB +: STREAM_W];
      state_next.srcChannel = lowWord[CML_CHAN_LSB +: CHAN_W];
      state_next.lawEnable = lowWord[CML_LAW_EN_BIT];
      // High word is masked off when conversion is disabled
      if (lowWord[CML_LAW_EN_BIT]) begin
        state_next.method = highPort.rdDataB;
      end else begin
        state_next.method = WORD_RESET;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hostDataOut = state_reg.dataOut;
  assign hostDataOe = state_reg.dataOe;
  assign hostAck = state_reg.ack;
  assign sampleDone = state_reg.sampleDone;
  assign sampleByte = state_reg.sampleByte;
  assign lookupDone = state_reg.lookupDone;
  assign lookupInvalid = state_reg.lookupInvalid;
  assign normalSwitch = state_reg.normalSwitch;
  assign variableDelay = state_reg.variableDelay;
  assign source_stream_field = state_reg.srcStream;
  assign sourceChannel = state_reg.srcChannel;
  assign law_conversion_enable = state_reg.lawEnable;
  assign conversionMethod = state_reg.method;

endmodule : tcma_access
`default_nettype wire

// ### tcma_pkg.sv
// Shared constants and helper functions for the connection memory access block
// Behaviour
// - Top address bit routes access to per-channel memory
// - Control bits 1-0 select data, low or high
// - 8.192 Mbps stream allows channels 0-127 only
// - 16.384 Mbps stream allows channels 0-255
// - Low word bit 0 zero means normal switching
// - Low word fields: enable, delay, stream, channel
// - Enable low: no conversion, ignore high word
// - Enable high: convert using high word method
package tcma_pkg;

  localparam int HOST_ADDR_W = 14;
  localparam int MEM_SPACE_BIT = 13;
  localparam int STREAM_W = 5;
  localparam int CHAN_W = 8;
  localparam int STREAM_LSB = 8;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_TOP_BIT = 7;
  localparam int INDEX_W = STREAM_W + CHAN_W;
  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_STREAMS = 32;

  // Memory select field of the control register, bits 1-0
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_CML = 2'h1;
  localparam logic [1:0] SEL_CMH = 2'h2;

  // Stream rate code per stream
  localparam logic RATE_8M = 1'b0;
  localparam logic RATE_16M = 1'b1;

  // connection_memory_low_word layout in switching mode
  localparam int CML_LAW_EN_BIT = 15;
  localparam int CML_DELAY_BIT = 14;
  localparam int CML_STREAM_LSB = 9;
  localparam int CML_CHAN_LSB = 1;
  localparam int CML_MODE_BIT = 0;

  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] UNMAPPED_READ = 16'h0000;

  // A slow stream owns only the lower half of the channel range
  function automatic logic tcma_chan_valid(input logic rate, input logic [CHAN_W-1:0] chan);
    tcma_chan_valid = (rate == RATE_16M) || !chan[CHAN_TOP_BIT];
  endfunction : tcma_chan_valid

  function automatic logic [INDEX_W-1:0] tcma_index(input logic [STREAM_W-1:0] stream,
                                                    input logic [CHAN_W-1:0] chan);
    tcma_index = {stream, chan};
  endfunction : tcma_index

endpackage : tcma_pkg

// ### tcma_mem_if.sv
// Port bundle between the access logic and one per-channel memory
`timescale 1ns/100ps
`default_nettype none
interface tcma_mem_if #(
  parameter int WIDTH = 16,
  parameter int AW = 13
);
  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [WIDTH-1:0] wrData;
  logic [AW-1:0] rdAddrA;
  logic [WIDTH-1:0] rdDataA;
  logic [AW-1:0] rdAddrB;
  logic [WIDTH-1:0] rdDataB;

  modport owner (output wrEn, output wrAddr, output wrData, output rdAddrA,
                 output rdAddrB, input rdDataA, input rdDataB);
  modport mem (input wrEn, input wrAddr, input wrData, input rdAddrA,
               input rdAddrB, output rdDataA, output rdDataB);
endinterface : tcma_mem_if
`default_nettype wire

// ### tcma_mem.sv
// One write, two registered read ports per-channel memory
`timescale 1ns/100ps
`default_nettype none
module tcma_mem
  import tcma_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int AW = 13
) (
  input wire logic clk,
  input wire logic rst_n,
  tcma_mem_if.mem port
);

  typedef struct packed {
    logic [WIDTH-1:0] rdA;
    logic [WIDTH-1:0] rdB;
  } tcma_mem_state_t;

  logic [WIDTH-1:0] store [2**AW];
  tcma_mem_state_t state_reg;
  tcma_mem_state_t state_next;

  // Array kept outside reset so it maps onto block RAM
  always_ff @(posedge clk) begin
    if (port.wrEn) begin
      store[port.wrAddr] <= port.wrData;
    end
  end

  // Read-before-write: a same-cycle read sees the old word
  always_comb begin
    state_next = state_reg;
    state_next.rdA = store[port.rdAddrA];
    state_next.rdB = store[port.rdAddrB];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign port.rdDataA = state_reg.rdA;
  assign port.rdDataB = state_reg.rdB;

endmodule : tcma_mem
`default_nettype wire

// ### tcma_access_assertions.sv
// Port-level assertions for the connection memory access block
`timescale 1ns/100ps
`default_nettype none
module tcma_access_assertions
  import tcma_pkg::*;
#(
  parameter int STREAMS = NUM_STREAMS
) (
  input wire logic clk, rst_n, hostSelect_n, hostRead_n, hostWrite_n,
  input wire logic [HOST_ADDR_W-1:0] hostAddr,
  input wire logic [1:0] memorySelect,
  input wire logic [WORD_W-1:0] hostDataOut, conversionMethod,
  input wire logic [STREAMS-1:0] streamRate,
  input wire logic hostAck, hostDataOe, lookupValid, lookupDone, lookupInvalid,
  input wire logic [STREAM_W-1:0] lookupStream,
  input wire logic [CHAN_W-1:0] lookupChannel,
  input wire logic law_conversion_enable, sampleValid, sampleDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  assign acc = !hostSelect_n && !(hostRead_n && hostWrite_n);
  sequence s_rd;
    $rose(acc) && !hostRead_n;
  endsequence
  sequence s_ack;
    !hostAck ##1 !hostAck ##1 hostAck ##1 !hostAck;
  endsequence
  property p_ack;
    $rose(acc) |-> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_oe;
    s_rd |=> hostDataOe;
  endproperty
  a_oe: assert property (p_oe) else $error("bus not driven on read");
  property p_off;
    $rose(acc) && !hostRead_n && !hostAddr[MEM_SPACE_BIT] |-> ##2 hostDataOut == UNMAPPED_READ;
  endproperty
  a_off: assert property (p_off) else $error("register space read not zero");
  property p_slow;
    $rose(acc) && !hostRead_n && hostAddr[13] && !streamRate[hostAddr[12:8]] && hostAddr[7]
      |-> ##2 hostDataOut == UNMAPPED_READ;
  endproperty
  a_slow: assert property (p_slow) else $error("slow channel read not zero");
  property p_lk;
    lookupValid && !streamRate[lookupStream] && lookupChannel[7] |-> ##2 lookupDone && lookupInvalid;
  endproperty
  a_lk: assert property (p_lk) else $error("slow channel not flagged");
  property p_lk16;
    lookupValid && streamRate[lookupStream] |-> ##2 lookupDone && !lookupInvalid;
  endproperty
  a_lk16: assert property (p_lk16) else $error("fast channel flagged");
  property p_conv;
    lookupDone && !law_conversion_enable |-> conversionMethod == 16'h0000;
  endproperty
  a_conv: assert property (p_conv) else $error("method seen while disabled");
  property p_smp;
    sampleValid |-> ##2 sampleDone;
  endproperty
  a_smp: assert property (p_smp) else $error("sample not answered");
  property p_nosel;
    $rose(acc) && !hostRead_n && memorySelect == 2'h3 |-> ##2 hostDataOut == UNMAPPED_READ;
  endproperty
  a_nosel: assert property (p_nosel) else $error("unused select read not zero");
endmodule : tcma_access_assertions
bind tcma_access tcma_access_assertions #(.STREAMS(STREAMS)) u_chk (.clk, .rst_n,
  .hostSelect_n, .hostRead_n, .hostWrite_n, .hostAddr, .memorySelect, .hostDataOut,
  .conversionMethod,
  .streamRate, .hostAck, .hostDataOe, .lookupValid, .lookupDone, .lookupInvalid,
  .lookupStream, .lookupChannel, .law_conversion_enable, .sampleValid, .sampleDone);
`default_nettype wire

// ### tcma_host_model.sv
// Host microprocessor model for the parallel port
`timescale 1ns/100ps
`default_nettype none
module tcma_host_model (
  input wire logic clk,
  output logic hostSelect_n,
  output logic hostRead_n,
  output logic hostWrite_n,
  output logic [13:0] hostAddr,
  output logic [15:0] hostDataIn,
  output logic [1:0] memorySelect,
  input wire logic hostAck,
  input wire logic [15:0] hostDataOut
);
  initial begin
    {hostSelect_n, hostRead_n, hostWrite_n} = 3'h7;
    hostAddr = 14'h0000;
    hostDataIn = 16'h0000;
    memorySelect = 2'h0;
  end
  task automatic xfer(input logic wr, input logic [13:0] a, input logic [15:0] d,
                      input logic [1:0] ms, output logic [15:0] q);
    int n;
    @(posedge clk);
    {hostSelect_n, hostRead_n, hostWrite_n} <= {1'b0, wr, !wr};
    hostAddr <= a;
    hostDataIn <= d;
    memorySelect <= ms;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!hostAck && n < 8);
    q = hostDataOut;
    {hostSelect_n, hostRead_n, hostWrite_n} <= 3'h7;
    // Released bus must not keep showing the old word
    hostDataIn <= ~d;
    hostAddr <= ~a;
  endtask : xfer
endmodule : tcma_host_model
`default_nettype wire

// ### tcma_access_tb.sv
// Self-checking bench for the connection memory access block
`timescale 1ns/100ps
`default_nettype none
module tcma_access_tb
  import tcma_pkg::*;
;
  logic clk, rst_n, hostSelect_n, hostRead_n, hostWrite_n, hostDataOe, hostAck;
  logic [13:0] hostAddr;
  logic [15:0] hostDataIn, hostDataOut, conversionMethod, q, w;
  logic [1:0] memorySelect;
  logic [31:0] streamRate, rnd;
  logic captureValid, sampleValid, sampleDone, lookupValid, lookupDone, lookupInvalid;
  logic [4:0] captureStream, sampleStream, lookupStream, source_stream_field, s;
  logic [7:0] captureChannel, captureByte, sampleChannel, sampleByte, lookupChannel;
  logic [7:0] sourceChannel, c;
  logic normalSwitch, variableDelay, law_conversion_enable;
  logic [15:0] cml [int];
  logic [15:0] cmh [int];
  int err_count, n_checks, cyc, k;
  tcma_access i_dut (.clk, .rst_n, .hostSelect_n, .hostRead_n, .hostWrite_n, .hostAddr,
    .hostDataIn, .hostDataOut, .hostDataOe, .hostAck, .memorySelect, .streamRate,
    .captureValid, .captureStream, .captureChannel, .captureByte, .sampleValid,
    .sampleStream, .sampleChannel, .sampleDone, .sampleByte, .lookupValid, .lookupStream,
    .lookupChannel, .lookupDone, .lookupInvalid, .normalSwitch, .variableDelay,
    .source_stream_field, .sourceChannel, .law_conversion_enable, .conversionMethod);
  tcma_host_model i_host (.clk, .hostSelect_n, .hostRead_n, .hostWrite_n, .hostAddr,
    .hostDataIn, .memorySelect, .hostAck, .hostDataOut);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic req(input logic lk, input logic [4:0] st, input logic [7:0] ch);
    @(posedge clk);
    if (lk) lookupValid <= 1'b1;
    else sampleValid <= 1'b1;
    {lookupStream, sampleStream, lookupChannel, sampleChannel} <= {st, st, ch, ch};
    @(posedge clk);
    {lookupValid, sampleValid} <= 2'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask : req
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    {rst_n, captureValid, sampleValid, lookupValid} = 4'h0;
    {captureStream, sampleStream, lookupStream} = 15'h0000;
    {captureChannel, captureByte, sampleChannel, lookupChannel} = 32'h0;
    // Upper half of the streams run at the fast rate
    streamRate = 32'hffff0000;
    rnd = 32'hc87b;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rnd = xs(rnd);
      s = rnd[4:0];
      c = {rnd[4] & rnd[12], rnd[11:5]};
      k = {s, c};
      cml[k] = rnd[31:16];
      rnd = xs(rnd);
      cmh[k] = rnd[15:0];
      i_host.xfer(1'b1, {1'b1, s, c}, cml[k], SEL_CML, q);
      i_host.xfer(1'b1, {1'b1, s, c}, cmh[k], SEL_CMH, q);
      i_host.xfer(1'b0, {1'b1, s, c}, 16'h0000, SEL_CML, q);
      chk(q, cml[k]);
      req(1'b1, s, c);
      w = cml[k];
      chk({normalSwitch, variableDelay, source_stream_field, sourceChannel,
           law_conversion_enable}, {!w[0], w[14], w[13:9], w[8:1], w[15]});
      chk(conversionMethod, w[15] ? cmh[k] : 16'h0000);
      chk({15'h0000, lookupInvalid}, 16'h0000);
    end
    i_host.xfer(1'b0, {1'b0, s, c}, 16'h0000, SEL_CML, q);
    chk(q, 16'h0000);
    // Writes outside memory space or to the data memory must be dropped
    i_host.xfer(1'b1, {1'b0, s, c}, ~cml[k], SEL_CML, q);
    i_host.xfer(1'b1, {1'b1, s, c}, ~cml[k], SEL_DATA, q);
    i_host.xfer(1'b0, {1'b1, s, c}, 16'h0000, SEL_CML, q);
    chk(q, cml[k]);
    i_host.xfer(1'b0, {1'b1, s, c}, 16'h0000, SEL_CMH, q);
    chk(q, cmh[k]);
    i_host.xfer(1'b0, {1'b1, s, c}, 16'h0000, 2'h3, q);
    chk(q, 16'h0000);
    // Seed the upper channel while fast, then show a slow-rate write is dropped
    streamRate[3] <= RATE_16M;
    i_host.xfer(1'b1, {1'b1, 5'h03, 8'h85}, rnd[15:0], SEL_CML, q);
    streamRate[3] <= RATE_8M;
    i_host.xfer(1'b1, {1'b1, 5'h03, 8'h85}, ~rnd[15:0], SEL_CML, q);
    i_host.xfer(1'b0, {1'b1, 5'h03, 8'h85}, 16'h0000, SEL_CML, q);
    chk(q, 16'h0000);
    streamRate[3] <= RATE_16M;
    i_host.xfer(1'b0, {1'b1, 5'h03, 8'h85}, 16'h0000, SEL_CML, q);
    chk(q, rnd[15:0]);
    streamRate[3] <= RATE_8M;
    req(1'b1, 5'h03, 8'h85);
    chk({15'h0000, lookupInvalid}, 16'h0001);
    @(posedge clk);
    {captureValid, captureStream, captureChannel, captureByte} <= {1'b1, s, c, rnd[23:16]};
    @(posedge clk);
    captureValid <= 1'b0;
    i_host.xfer(1'b0, {1'b1, s, c}, 16'h0000, SEL_DATA, q);
    chk(q, {8'h00, rnd[23:16]});
    req(1'b0, s, c);
    chk({8'h00, sampleByte}, {8'h00, rnd[23:16]});
    stop_test();
  end
endmodule : tcma_access_tb
`default_nettype wire
